// ===== verilog/lai_top.sv
// Line alarm monitor with change events and an AHB-Lite register slave.
//
// Functional notes
// - Loss-of-signal change raises interrupt when enabled.
// - Test-pattern detect change raises interrupt when enabled.
// - Enable, status, control work only single-rail; here only status and events are gated.
// - Alarm after 128 bit periods without pulse.
// - Alarm clears at once on bipolar activity.
// - Status bit 6 shows driver alarm, reads only.
// - Driver alarm change raises interrupt when enabled.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module lai_top (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave, address and control.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  // AHB-Lite slave, data and response.
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Receive section conditions, asynchronous to hclk.
  input wire logic rx_signal_loss,
  input wire logic rx_test_pattern_detect,
  // Transmit line pair pulses, asynchronous to hclk.
  input wire logic tx_line_tip,
  input wire logic tx_line_ring,
  // One-cycle strobe marking each transmit bit period, from hclk logic.
  input wire logic tx_bit_tick,
  // Outputs: alarm level and one-cycle interrupt events.
  output logic driver_monitor_alarm,
  output logic rx_signal_loss_change_irq,
  output logic test_pattern_detect_change_irq,
  output logic driver_monitor_change_irq
);

  // Two-stage synchronisers for the four asynchronous inputs.
  logic [3:0] sync1_q; // First stage; only the second stage reads it.
  logic [3:0] sync2_q; // Second stage; safe to use in logic.
  logic [3:0] async_in; // Gathered raw inputs.

  assign async_in = {tx_line_ring, tx_line_tip, rx_test_pattern_detect,
                     rx_signal_loss};

  // Synchronise each pin; the first stage feeds nothing but the second.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  // Synchronised conditions.
  logic loss_s; // Receive loss-of-signal defect.
  logic pattern_s; // Receive test pattern detected.
  logic activity_s; // A bipolar pulse on either transmit leg.

  assign loss_s = sync2_q[0];
  assign pattern_s = sync2_q[1];
  assign activity_s = sync2_q[2] | sync2_q[3];

  // The bit-period strobe is delayed two clocks so that it lines up with
  // the synchronised pulses. A pulse in the strobe's own bit period then
  // wins over the strobe, and cannot count as a quiet period.
  logic tick_d1_q; // Strobe one clock late.
  logic tick_d2_q; // Strobe two clocks late, level with activity_s.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_d1_q <= 1'b0;
      tick_d2_q <= 1'b0;
    end else begin
      tick_d1_q <= tx_bit_tick;
      tick_d2_q <= tick_d1_q;
    end
  end

  // Registers seen by software.
  logic [7:0] irq_en_q; // Change interrupt enables.
  logic [7:0] irq_en_d;
  logic [7:0] control_q; // Holds the single-rail select.
  logic [7:0] control_d;
  logic single_rail; // Single-rail mode is selected.

  assign single_rail = control_q[lai_pkg::LAI_BIT_SINGLE_RAIL];

  // Driver monitor: count quiet bit periods.
  logic [7:0] quiet_cnt_q; // Bit periods seen with no pulse.
  logic alarm_q; // Driver alarm as declared.

  // The alarm is declared on the tick that completes the quiet run and
  // dropped in the cycle after any pulse, tick or not, so that a
  // returning signal is never held off by the bit-period strobe.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quiet_cnt_q <= 8'h00;
      alarm_q <= 1'b0;
    end else if (activity_s) begin
      quiet_cnt_q <= 8'h00;
      alarm_q <= 1'b0;
    end else if (tick_d2_q) begin
      if (quiet_cnt_q == lai_pkg::LAI_QUIET_LAST) begin
        alarm_q <= 1'b1;
      end else begin
        quiet_cnt_q <= quiet_cnt_q + 8'h01;
      end
    end
  end

  // Previous samples for change detection.
  lai_pkg::lai_cond_t cond_now; // Current conditions.
  lai_pkg::lai_cond_t cond_prev_q; // Conditions one cycle earlier.
  lai_pkg::lai_cond_t change; // One-cycle change events.

  assign cond_now = '{driver: alarm_q, loss: loss_s, pattern: pattern_s};
  assign change = cond_now ^ cond_prev_q;

  // Keep the previous sample of each condition.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cond_prev_q <= '0;
    end else begin
      cond_prev_q <= cond_now;
    end
  end

  // Registered interrupt events; suppressed outside single-rail mode.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_signal_loss_change_irq <= 1'b0;
      test_pattern_detect_change_irq <= 1'b0;
      driver_monitor_change_irq <= 1'b0;
    end else begin
      rx_signal_loss_change_irq <= change.loss & single_rail &
        irq_en_q[lai_pkg::LAI_BIT_LOSS];
      test_pattern_detect_change_irq <= change.pattern & single_rail &
        irq_en_q[lai_pkg::LAI_BIT_PATTERN];
      driver_monitor_change_irq <= change.driver & single_rail &
        irq_en_q[lai_pkg::LAI_BIT_DRIVER];
    end
  end

  // The alarm level is also brought out for the transmit section.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      driver_monitor_alarm <= 1'b0;
    end else begin
      driver_monitor_alarm <= alarm_q;
    end
  end

  // Bus address phase capture.
  lai_pkg::lai_ahb_req_t req_q; // Request held for its data phase.
  logic accept; // A valid transfer is taken this cycle.
  logic wr_pending_q; // A write is in its data phase.
  logic [13:0] req_idx; // Register index of the held request.
  logic [13:0] new_idx; // Register index of the incoming request.

  assign accept = hsel & hready & (htrans == lai_pkg::LAI_HTRANS_NONSEQ);
  assign req_idx = req_q.addr[15:2];
  assign new_idx = haddr[15:2];

  // Hold the address phase; only the write path needs it later.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
      wr_pending_q <= 1'b0;
    end else if (hready) begin
      req_q <= '{sel: hsel, trans: htrans, write: hwrite, size: hsize,
                 addr: haddr};
      wr_pending_q <= accept & hwrite;
    end
  end

  // Next values of the writable registers; unmapped writes are dropped.
  always_comb begin
    irq_en_d = irq_en_q;
    control_d = control_q;
    if (wr_pending_q && hready) begin
      if (req_idx == lai_pkg::LAI_IDX_IRQ_ENABLE) begin
        irq_en_d = hwdata[7:0] & lai_pkg::LAI_WMASK_IRQ_ENABLE;
      end else if (req_idx == lai_pkg::LAI_IDX_CONTROL) begin
        control_d = hwdata[7:0] & lai_pkg::LAI_WMASK_CONTROL;
      end
    end
  end

  // Store enables and control.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en_q <= lai_pkg::LAI_RST_IRQ_ENABLE;
      control_q <= lai_pkg::LAI_RST_CONTROL;
    end else begin
      irq_en_q <= irq_en_d;
      control_q <= control_d;
    end
  end

  // Read mux; it looks at next values so a read right after a write
  // sees the new contents. Status reads zero outside single-rail mode.
  logic [7:0] status_val; // Live status byte.
  logic [31:0] rdata_d; // Data for the coming data phase.

  always_comb begin
    status_val = 8'h00;
    if (single_rail) begin
      status_val[lai_pkg::LAI_BIT_DRIVER] = alarm_q;
      status_val[lai_pkg::LAI_BIT_LOSS] = loss_s;
      status_val[lai_pkg::LAI_BIT_PATTERN] = pattern_s;
    end
    rdata_d = 32'h0000_0000;
    if (new_idx == lai_pkg::LAI_IDX_IRQ_ENABLE) begin
      rdata_d = {24'h00_0000, irq_en_d};
    end else if (new_idx == lai_pkg::LAI_IDX_STATUS) begin
      rdata_d = {24'h00_0000, status_val};
    end else if (new_idx == lai_pkg::LAI_IDX_CONTROL) begin
      rdata_d = {24'h00_0000, control_d};
    end
  end

  // Read data is loaded at the end of the address phase, zero waits.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= lai_pkg::LAI_RST_RDATA;
    end else if (accept && !hwrite) begin
      hrdata <= rdata_d;
    end
  end

  // The slave never stalls and always answers OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Checks on the behaviour above.
  property p_alarm_declare;
    @(posedge hclk) disable iff (!hresetn)
      $rose(alarm_q) |-> $past(quiet_cnt_q) == 8'd127 && $past(tick_d2_q);
  endproperty
  a_alarm_declare: assert property (p_alarm_declare)
    else $error("driver alarm declared before 128 quiet bits");

  property p_alarm_reach;
    @(posedge hclk) disable iff (!hresetn)
      (quiet_cnt_q == 8'd127 && tick_d2_q && !activity_s) |=> alarm_q;
  endproperty
  a_alarm_reach: assert property (p_alarm_reach)
    else $error("driver alarm missing after 128 quiet bits");

  property p_alarm_clear;
    @(posedge hclk) disable iff (!hresetn)
      activity_s |=> !alarm_q && quiet_cnt_q == 8'd0;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear)
    else $error("driver alarm not cleared by activity");

  property p_loss_irq;
    @(posedge hclk) disable iff (!hresetn)
      rx_signal_loss_change_irq == $past(change.loss &&
        irq_en_q[1] && single_rail);
  endproperty
  a_loss_irq: assert property (p_loss_irq)
    else $error("loss change event wrong");

  property p_pattern_irq;
    @(posedge hclk) disable iff (!hresetn)
      ($changed(pattern_s) && irq_en_q[0] && single_rail)
        |=> test_pattern_detect_change_irq;
  endproperty
  a_pattern_irq: assert property (p_pattern_irq)
    else $error("pattern change event missing");

  property p_driver_irq;
    @(posedge hclk) disable iff (!hresetn)
      driver_monitor_change_irq |-> $past(irq_en_q[6]) &&
        driver_monitor_alarm != $past(driver_monitor_alarm);
  endproperty
  a_driver_irq: assert property (p_driver_irq)
    else $error("driver change event without alarm change");

  property p_rail_gate;
    @(posedge hclk) disable iff (!hresetn)
      !single_rail |=> !(rx_signal_loss_change_irq ||
        test_pattern_detect_change_irq || driver_monitor_change_irq);
  endproperty
  a_rail_gate: assert property (p_rail_gate)
    else $error("event raised outside single-rail mode");

  property p_status_read;
    @(posedge hclk) disable iff (!hresetn)
      (accept && !hwrite && new_idx == 14'h0f05)
        |=> hrdata[6] == ($past(alarm_q) && $past(single_rail)) &&
            hrdata[7] == 1'b0;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read shows wrong driver alarm");

  property p_event_single;
    @(posedge hclk) disable iff (!hresetn)
      rx_signal_loss_change_irq |=> !rx_signal_loss_change_irq ||
        $past(change.loss);
  endproperty
  a_event_single: assert property (p_event_single)
    else $error("loss event longer than its change");

  c_alarm_up: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(driver_monitor_alarm));
  c_alarm_down: cover property (@(posedge hclk) disable iff (!hresetn)
    $fell(driver_monitor_alarm) && driver_monitor_change_irq);
  c_loss_evt: cover property (@(posedge hclk) disable iff (!hresetn)
    rx_signal_loss_change_irq);
  c_enable_write: cover property (@(posedge hclk) disable iff (!hresetn)
    irq_en_q != $past(irq_en_q));

endmodule : lai_top

`default_nettype wire

// ===== verilog/lai_pkg.sv
// Package with constants and carrier types for the line alarm interrupt block.
package lai_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [13:0] LAI_IDX_IRQ_ENABLE = 14'h0f04;
  localparam logic [13:0] LAI_IDX_STATUS = 14'h0f05;
  localparam logic [13:0] LAI_IDX_CONTROL = 14'h0f06;

  // Bit positions in the enable and status registers.
  localparam int LAI_BIT_PATTERN = 0;
  localparam int LAI_BIT_LOSS = 1;
  localparam int LAI_BIT_DRIVER = 6;
  // Bit position of the single-rail select in the control register.
  localparam int LAI_BIT_SINGLE_RAIL = 0;

  // Values after reset.
  localparam logic [7:0] LAI_RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] LAI_RST_CONTROL = 8'h00;
  localparam logic [31:0] LAI_RST_RDATA = 32'h0000_0000;

  // Writable bits of the enable and control registers.
  localparam logic [7:0] LAI_WMASK_IRQ_ENABLE = 8'h43;
  localparam logic [7:0] LAI_WMASK_CONTROL = 8'h01;

  // Bit periods without a bipolar pulse before the driver alarm is declared.
  localparam int LAI_QUIET_BITS = 128;
  localparam logic [7:0] LAI_QUIET_LAST = 8'(LAI_QUIET_BITS - 1);

  // AHB transfer type code for a non-sequential transfer.
  localparam logic [1:0] LAI_HTRANS_NONSEQ = 2'h2;

  // Address-phase request as the slave captures it.
  typedef struct packed {
    logic sel;
    logic [1:0] trans;
    logic write;
    logic [2:0] size;
    logic [31:0] addr;
  } lai_ahb_req_t;

  // Sampled alarm conditions and the change events derived from them.
  typedef struct packed {
    logic driver;
    logic loss;
    logic pattern;
  } lai_cond_t;

endpackage : lai_pkg

// ===== sim/lai_line_model.sv
// Behavioural model of the line transformer side of the alarm block.
`timescale 1ns/1ps
`default_nettype none

module lai_line_model (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Commands from the bench.
  input wire logic quiet,
  input wire logic loss_cmd,
  input wire logic pat_cmd,
  // Line side levels and the bit period strobe.
  output logic tick,
  output logic tip,
  output logic ring,
  output logic loss,
  output logic pat
);
  logic [1:0] ph_q; // Bit period phase; one bit lasts four clocks.
  logic leg_q; // Alternates pulses between the legs, as bipolar code does.

  // Pulses sit on the tick cycle, so a tick without a pulse is quiet.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 2'h0;
      leg_q <= 1'b0;
      tick <= 1'b0;
      tip <= 1'b0;
      ring <= 1'b0;
    end else begin
      ph_q <= ph_q + 2'h1;
      tick <= (ph_q == 2'h3);
      // Idle legs sit low, which the monitor reads as no pulse.
      tip <= (ph_q == 2'h3) && !quiet && leg_q;
      ring <= (ph_q == 2'h3) && !quiet && !leg_q;
      if (ph_q == 2'h3) begin
        leg_q <= ~leg_q;
      end
    end
  end

  // Receive conditions follow the commanded levels one clock later.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loss <= 1'b0;
      pat <= 1'b0;
    end else begin
      loss <= loss_cmd;
      pat <= pat_cmd;
    end
  end
endmodule : lai_line_model

`default_nettype wire

// ===== sim/lai_top_tb.sv
// Self-checking bench for the line alarm interrupt block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end

module lai_top_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, wd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic alarm, irq_loss, irq_pat, irq_drv;
  logic tick, tip, ring, loss, pat, quiet, loss_cmd, pat_cmd;
  int num_errors, n_compared, n_loss, n_pat, n_drv, k;
  logic [31:0] seed = 32'h0000_5f53;
  logic [7:0] en_m; // Model of the enable register.
  logic sr_m, alm_m; // Model of single-rail select and alarm.

  // Fixed-seed xorshift source for register values and toggle counts.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Status as the model predicts it; all zero outside single-rail mode.
  function automatic logic [7:0] exp_st();
    return sr_m ? {1'b0, alm_m, 4'h0, loss_cmd, pat_cmd} : 8'h00;
  endfunction : exp_st

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  lai_top u_lai_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_signal_loss(loss),
    .rx_test_pattern_detect(pat), .tx_line_tip(tip), .tx_line_ring(ring),
    .tx_bit_tick(tick), .driver_monitor_alarm(alarm),
    .rx_signal_loss_change_irq(irq_loss),
    .test_pattern_detect_change_irq(irq_pat),
    .driver_monitor_change_irq(irq_drv));

  lai_line_model u_lai_line_model (.hclk(hclk), .hresetn(hresetn),
    .quiet(quiet), .loss_cmd(loss_cmd), .pat_cmd(pat_cmd), .tick(tick),
    .tip(tip), .ring(ring), .loss(loss), .pat(pat));

  // Counts clocks on which each event line is high; a stuck pulse shows.
  always @(posedge hclk) begin
    if (irq_loss !== 1'b0) n_loss++;
    if (irq_pat !== 1'b0) n_pat++;
    if (irq_drv !== 1'b0) n_drv++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // One single AHB-Lite transfer; read data is left in rd.
  task automatic bus(input logic wr, input logic [13:0] idx,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= lai_pkg::LAI_HTRANS_NONSEQ;
    haddr <= {16'h0000, idx, 2'b00};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask : bus

  task automatic chk(input logic [13:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 32'h0000_0000);
    `CHK(rd, {24'h000000, e})
  endtask : chk

  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Watchdog: the whole run needs well under 20000 clocks.
  initial begin
    #(50 * 20000);
    num_errors++;
    report_and_stop();
  end

  initial begin
    {hsel, hwrite, quiet, loss_cmd, pat_cmd, hresetn, sr_m, alm_m} = '0;
    {haddr, hwdata, htrans, en_m} = '0;
    hsize = 3'h2;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    chk(lai_pkg::LAI_IDX_IRQ_ENABLE, 8'h00);
    chk(lai_pkg::LAI_IDX_STATUS, 8'h00);
    bus(1'b1, 14'h0f07, xs());
    chk(14'h0f07, 8'h00);
    bus(1'b1, lai_pkg::LAI_IDX_IRQ_ENABLE, 32'h0000_00ff);
    en_m = 8'hff & lai_pkg::LAI_WMASK_IRQ_ENABLE;
    chk(lai_pkg::LAI_IDX_IRQ_ENABLE, en_m);
    // Outside single-rail mode a change must stay silent.
    loss_cmd <= 1'b1;
    cyc(8);
    chk(lai_pkg::LAI_IDX_STATUS, 8'h00);
    `CHK(n_loss, 0)
    loss_cmd <= 1'b0;
    cyc(8);
    // Software selects single-rail mode before using the alarms.
    bus(1'b1, lai_pkg::LAI_IDX_CONTROL, 32'h0000_0001);
    sr_m = 1'b1;
    for (int e = 0; e < 4; e++) begin
      wd = {xs() & 32'hffff_ffbc} | e;
      en_m = wd[7:0] & lai_pkg::LAI_WMASK_IRQ_ENABLE;
      bus(1'b1, lai_pkg::LAI_IDX_IRQ_ENABLE, wd);
      n_loss = 0;
      n_pat = 0;
      k = 1 + (xs() % 4);
      repeat (k) begin
        loss_cmd <= ~loss_cmd;
        cyc(6);
        pat_cmd <= ~pat_cmd;
        cyc(6);
      end
      `CHK(n_loss, en_m[1] ? k : 0)
      `CHK(n_pat, en_m[0] ? k : 0)
      chk(lai_pkg::LAI_IDX_STATUS, exp_st());
    end
    // Driver monitor, once with its event enabled and once without.
    for (int e = 1; e >= 0; e--) begin
      bus(1'b1, lai_pkg::LAI_IDX_IRQ_ENABLE, e ? 32'h40 : 32'h00);
      n_drv = 0;
      quiet <= 1'b1;
      k = 0;
      do begin
        @(posedge hclk);
        if (tick === 1'b1) k = (tip | ring) ? 0 : k + 1;
      end while (k < 127);
      do @(posedge hclk); while (tick !== 1'b1);
      `CHK(alarm, 1'b0)
      cyc(4);
      `CHK(alarm, 1'b1)
      alm_m = 1'b1;
      chk(lai_pkg::LAI_IDX_STATUS, exp_st());
      bus(1'b1, lai_pkg::LAI_IDX_STATUS, 32'h0000_0000);
      chk(lai_pkg::LAI_IDX_STATUS, exp_st());
      quiet <= 1'b0;
      do @(posedge hclk); while ((tip | ring) !== 1'b1);
      cyc(4);
      `CHK(alarm, 1'b0)
      alm_m = 1'b0;
      cyc(2);
      `CHK(n_drv, e ? 2 : 0)
    end
    // A pulse in the 128th bit period keeps the alarm and its event down.
    bus(1'b1, lai_pkg::LAI_IDX_IRQ_ENABLE, 32'h0000_0040);
    n_drv = 0;
    quiet <= 1'b1;
    k = 0;
    do begin
      @(posedge hclk);
      if (tick === 1'b1) k = (tip | ring) ? 0 : k + 1;
    end while (k < 127);
    quiet <= 1'b0;
    cyc(16);
    `CHK(n_drv, 0)
    `CHK(alarm, 1'b0)
    report_and_stop();
  end
endmodule : lai_top_tb

`default_nettype wire
